// >>> core/psc_pkg.sv
/*
 Shared constants and types of the power-management control register bank:
 register indices, field positions, reset values, timing counts and carriers.
 Assumes a 125 MHz core clock and a 32-bit APB with one register per word.
*/
`default_nettype none
package psc_pkg;
    // Bus widths
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_REGULATOR11_CONTROL_LEVEL = 8'h90;
    localparam logic [7:0] IDX_REGULATOR11_CONTROL_CTRL = 8'h91;
    localparam logic [7:0] IDX_REGULATOR12_CONTROL_LEVEL = 8'hA0;
    localparam logic [7:0] IDX_REGULATOR12_CONTROL_CTRL = 8'hA1;
    localparam logic [7:0] IDX_KEEPALIVE = 8'hB1;
    localparam logic [7:0] IDX_BUTTON_WDOG = 8'hC0;
    localparam logic [7:0] IDX_IRQ_SRC = 8'hC1;
    localparam logic [7:0] IDX_BUTTON_STAT = 8'hC2;
    localparam logic [7:0] IDX_SPC_REQ = 8'hC3;
    localparam logic [7:0] IDX_RESET_CAUSE = 8'hC5;
    localparam logic [7:0] IDX_PIN6 = 8'hE3;
    localparam logic [7:0] IDX_PIN5 = 8'hE4;
    localparam logic [7:0] IDX_PIN3 = 8'hF4;
    localparam logic [7:0] IDX_PIN4 = 8'hF5;
    // Regulator control byte fields
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_BLEED_BIT = 2;
    localparam int CTRL_FAULT_IRQ_BIT = 1;
    localparam int CTRL_PGOOD_BIT = 0;
    localparam int LEVEL_W = 6;
    // Button and watchdog control byte fields
    localparam int BW_PRESS_EN_BIT = 7;
    localparam int BW_RELEASE_EN_BIT = 6;
    localparam int BW_WD_SOFT_BIT = 1;
    localparam int BW_WD_CYCLE_BIT = 0;
    // Button status byte fields
    localparam int BS_PRESS_FLAG_BIT = 7;
    localparam int BS_RELEASE_FLAG_BIT = 6;
    localparam int BS_LIVE_BIT = 5;
    // Soft power cycle and reset cause fields
    localparam int SPC_BIT = 0;
    localparam int RC_POWER_CYCLED_BIT = 1;
    localparam int RC_SOFT_RESET_BIT = 0;
    // Reset values
    localparam logic [7:0] IRQ_SRC_IDLE = 8'hFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [5:0] LEVEL_RESET = 6'h00;
    localparam logic [7:0] BW_RESET = 8'h00;
    localparam logic KEEPALIVE_RESET = 1'b1;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    // Timing: software power cycle delay
    localparam int CLK_PERIOD_NS = 8;
    localparam int SPC_DELAY_NS = 8000000;
    localparam int SPC_DELAY_CYC = (SPC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [APB_DW-1:0] pwdata;
    } psc_apb_req_t;

    typedef struct packed {
        logic [APB_DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } psc_apb_rsp_t;

    typedef struct packed {
        logic pulse_enable;
        logic [2:0] rate_select;
        logic [3:0] ratio_select;
    } psc_pin_cfg_t;

    typedef enum logic [1:0] {
        SPC_IDLE = 2'b01,
        SPC_WAIT = 2'b10
    } psc_spc_state_t;
endpackage
`default_nettype wire

// >>> core/psc_register_bank.sv
/*
 Control and status register bank of the power-management device: regulator
 controls, push-button interrupt logic, interrupt source address, watchdog
 actions, software power cycle timer, reset-cause flags and pin pulse setup.
 Assumes an APB master on the core clock; power-good, fault and button inputs
 come from pins and are synchronised here; watchdog and sleep pulses come from
 logic on the same clock.
*/
`default_nettype none
module psc_register_bank
    import psc_pkg::*;
#(
    parameter int SPC_DELAY_CYCLES = SPC_DELAY_CYC,
    parameter logic [7:0] BUTTON_BLOCK_ADDR = 8'hC0,
    parameter logic [7:0] REGULATOR11_CONTROL_BLOCK_ADDR = 8'h90,
    parameter logic [7:0] REGULATOR12_CONTROL_BLOCK_ADDR = 8'hA0
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire psc_apb_req_t i_apb,
    output psc_apb_rsp_t o_apb,
    input wire logic [1:0] i_power_good,
    input wire logic [1:0] i_reg_fault,
    input wire logic i_button_n,
    input wire logic i_watchdog_expired,
    input wire logic i_sleep_entry,
    output logic [1:0] o_reg_enable,
    output logic [1:0] o_reg_bleed,
    output logic [1:0][LEVEL_W-1:0] o_reg_level,
    output logic o_keepalive_enable,
    output logic o_irq_pending,
    output logic o_soft_reset_start,
    output logic o_power_cycle_start,
    output psc_pin_cfg_t [3:0] o_pin_cfg
);
    localparam int CNT_W = $clog2(SPC_DELAY_CYCLES + 1);
    localparam logic [CNT_W-1:0] SPC_LAST = CNT_W'(SPC_DELAY_CYCLES - 1);
    // Pin slot order: 0 pin3, 1 pin4, 2 pin5, 3 pin6
    localparam logic [3:0][7:0] PIN_IDX = {IDX_PIN6, IDX_PIN5, IDX_PIN4, IDX_PIN3};
    localparam logic [1:0][7:0] CTRL_IDX = {IDX_REGULATOR12_CONTROL_CTRL, IDX_REGULATOR11_CONTROL_CTRL};
    localparam logic [1:0][7:0] LEVEL_IDX = {IDX_REGULATOR12_CONTROL_LEVEL, IDX_REGULATOR11_CONTROL_LEVEL};
    localparam logic [1:0][7:0] REG_BLOCK = {REGULATOR12_CONTROL_BLOCK_ADDR, REGULATOR11_CONTROL_BLOCK_ADDR};

    psc_apb_rsp_t apb_rsp_ff;
    logic [7:0] rd_byte_ff;
    logic [7:0] rd_byte;
    logic rd_valid;
    logic [7:0] bw_ff;
    logic [7:0] irq_src_ff;
    logic [7:0] nxt_irq_src;
    logic press_flag_ff;
    logic release_flag_ff;
    logic btn_s1_ff;
    logic btn_s2_ff;
    logic btn_prev_ff;
    logic keepalive_ff;
    logic power_cycled_ff;
    logic soft_reset_flag_ff;
    logic irq_pending_ff;
    logic soft_reset_start_ff;
    logic power_cycle_start_ff;
    psc_spc_state_t spc_state_ff;
    psc_spc_state_t nxt_spc_state;
    logic [CNT_W-1:0] spc_cnt_ff;
    psc_pin_cfg_t [3:0] pin_cfg_ff;
    logic [1:0][7:0] ctrl_rd;
    logic [1:0][7:0] level_rd;
    logic [1:0] fault_event;
    logic [1:0] ctrl_hit;
    logic [1:0] level_hit;
    logic [3:0] pin_hit;

    // Every assertion below runs on the core clock and sleeps through reset
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // APB decode: word aligned, index in paddr[9:2]
    wire access_ph = i_apb.psel && i_apb.penable;
    wire xfer_done = access_ph && apb_rsp_ff.pready;
    wire [7:0] idx = i_apb.paddr[9:2];
    wire addr_ok = (i_apb.paddr[1:0] == 2'b00) && (i_apb.paddr[APB_AW-1:10] == 2'b00);
    wire wr_done = xfer_done && i_apb.pwrite && rd_valid;
    wire rd_done = xfer_done && !i_apb.pwrite && rd_valid;
    wire [7:0] wbyte = i_apb.pwdata[7:0];
    wire wr_bw = wr_done && (idx == IDX_BUTTON_WDOG);
    wire wr_keep = wr_done && (idx == IDX_KEEPALIVE);
    wire wr_spc = wr_done && (idx == IDX_SPC_REQ);
    wire rd_irq_src = rd_done && (idx == IDX_IRQ_SRC);
    wire rd_cause = rd_done && (idx == IDX_RESET_CAUSE);

    // Button events from the synchronised, active-low input
    wire btn_pressed = !btn_s2_ff;
    wire press_event = !btn_s2_ff && btn_prev_ff && bw_ff[BW_PRESS_EN_BIT];
    wire release_event = btn_s2_ff && !btn_prev_ff && bw_ff[BW_RELEASE_EN_BIT];

    // Watchdog: power cycle outranks soft reset when both are armed
    wire wd_cycle = i_watchdog_expired && bw_ff[BW_WD_CYCLE_BIT];
    wire wd_soft = i_watchdog_expired && bw_ff[BW_WD_SOFT_BIT] && !wd_cycle;
    wire spc_fire = (spc_state_ff == SPC_WAIT) && (spc_cnt_ff == SPC_LAST);
    wire nxt_power_cycle = wd_cycle || spc_fire;

    // Per-regulator control, level and status
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_reg
            logic [7:0] ctrl_ff;
            logic [LEVEL_W-1:0] level_ff;
            logic pg_s1_ff;
            logic pg_s2_ff;
            logic flt_s1_ff;
            logic flt_s2_ff;
            logic flt_prev_ff;
            logic bleed_ff;
            logic [7:0] nxt_ctrl;

            assign ctrl_hit[gi] = wr_done && (idx == CTRL_IDX[gi]);
            assign level_hit[gi] = wr_done && (idx == LEVEL_IDX[gi]);
            // Only enable, bleed and fault-enable bits are stored
            assign nxt_ctrl = ctrl_hit[gi] ? (wbyte & 8'h86) : ctrl_ff;
            // Fault counts only on its rising edge while the regulator may interrupt
            assign fault_event[gi] = flt_s2_ff && !flt_prev_ff && ctrl_ff[CTRL_FAULT_IRQ_BIT];
            assign ctrl_rd[gi] = {ctrl_ff[7:1], pg_s2_ff};
            assign level_rd[gi] = {2'b00, level_ff};

            always_ff @(posedge i_core_clk)
            begin
                if (i_rst)
                begin
                    ctrl_ff <= CTRL_RESET;
                    level_ff <= LEVEL_RESET;
                    bleed_ff <= 1'b0;
                    pg_s1_ff <= 1'b0;
                    pg_s2_ff <= 1'b0;
                    flt_s1_ff <= 1'b0;
                    flt_s2_ff <= 1'b0;
                    flt_prev_ff <= 1'b0;
                end
                else
                begin
                    ctrl_ff <= nxt_ctrl;
                    if (level_hit[gi])
                        level_ff <= wbyte[LEVEL_W-1:0];
                    bleed_ff <= nxt_ctrl[CTRL_BLEED_BIT] && !nxt_ctrl[CTRL_ENABLE_BIT];
                    pg_s1_ff <= i_power_good[gi];
                    pg_s2_ff <= pg_s1_ff;
                    flt_s1_ff <= i_reg_fault[gi];
                    flt_s2_ff <= flt_s1_ff;
                    flt_prev_ff <= flt_s2_ff;
                end
            end

            assign o_reg_enable[gi] = ctrl_ff[CTRL_ENABLE_BIT];
            assign o_reg_level[gi] = level_ff;
            assign o_reg_bleed[gi] = bleed_ff;

            a_bleed_when_off: assert property (o_reg_bleed[gi] |-> !o_reg_enable[gi])
                else $error("bleed active while regulator on");
            // Synchronisers are forced low in reset, so skip the two edges after it
            a_pgood_delay: assert property (!$past(i_rst) && !$past(i_rst, 2) |->
                ctrl_rd[gi][CTRL_PGOOD_BIT] == $past(i_power_good[gi], 2))
                else $error("power-good status not two cycles behind input");
            a_reserved_zero: assert property ((ctrl_rd[gi][6:3] == 4'h0) && (level_rd[gi][7:6] == 2'b00))
                else $error("reserved regulator bits not zero");
        end
    endgenerate

    // Pin pulse setup bytes; codes are decoded by the pulse generator
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pin
            assign pin_hit[gi] = wr_done && (idx == PIN_IDX[gi]);
            always_ff @(posedge i_core_clk)
            begin
                if (i_rst)
                    pin_cfg_ff[gi] <= '0;
                else if (pin_hit[gi])
                    pin_cfg_ff[gi] <= psc_pin_cfg_t'(wbyte);
            end
        end
    endgenerate

    // Read selection; a miss flags pslverr
    always_comb
    begin
        rd_byte = 8'h00;
        rd_valid = addr_ok;
        unique case (idx)
            IDX_REGULATOR11_CONTROL_LEVEL: rd_byte = level_rd[0];
            IDX_REGULATOR11_CONTROL_CTRL: rd_byte = ctrl_rd[0];
            IDX_REGULATOR12_CONTROL_LEVEL: rd_byte = level_rd[1];
            IDX_REGULATOR12_CONTROL_CTRL: rd_byte = ctrl_rd[1];
            IDX_KEEPALIVE: rd_byte = {keepalive_ff, 7'h00};
            IDX_BUTTON_WDOG: rd_byte = bw_ff;
            IDX_IRQ_SRC: rd_byte = irq_src_ff;
            IDX_BUTTON_STAT: rd_byte = {press_flag_ff, release_flag_ff, btn_pressed, 5'h00};
            IDX_SPC_REQ: rd_byte = {7'h00, spc_state_ff == SPC_WAIT};
            IDX_RESET_CAUSE: rd_byte = {6'h00, power_cycled_ff, soft_reset_flag_ff};
            IDX_PIN3: rd_byte = pin_cfg_ff[0];
            IDX_PIN4: rd_byte = pin_cfg_ff[1];
            IDX_PIN5: rd_byte = pin_cfg_ff[2];
            IDX_PIN6: rd_byte = pin_cfg_ff[3];
            default: rd_valid = 1'b0;
        endcase
    end

    // One wait state: data is captured in the first access cycle, pready follows
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            apb_rsp_ff <= '{prdata: RDATA_RESET, pready: 1'b0, pslverr: 1'b0};
            rd_byte_ff <= 8'h00;
        end
        else
        begin
            apb_rsp_ff.pready <= access_ph && !apb_rsp_ff.pready;
            apb_rsp_ff.pslverr <= access_ph && !apb_rsp_ff.pready && !rd_valid;
            if (access_ph && !apb_rsp_ff.pready)
            begin
                // A refused access returns zero even when the index itself decodes
                apb_rsp_ff.prdata <= (i_apb.pwrite || !rd_valid) ? RDATA_RESET : {24'h000000, rd_byte};
                rd_byte_ff <= rd_byte;
            end
        end
    end

    // Interrupt source: a new event wins over the read restore; the restore
    // only applies if the byte still holds what the host was shown
    always_comb
    begin
        nxt_irq_src = irq_src_ff;
        if (rd_irq_src && (irq_src_ff == rd_byte_ff))
            nxt_irq_src = IRQ_SRC_IDLE;
        if (fault_event[1])
            nxt_irq_src = REG_BLOCK[1];
        if (fault_event[0])
            nxt_irq_src = REG_BLOCK[0];
        if (press_event || release_event)
            nxt_irq_src = BUTTON_BLOCK_ADDR;
    end

    // Button sync, flags, watchdog enables and interrupt source
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            btn_s1_ff <= 1'b1;
            btn_s2_ff <= 1'b1;
            btn_prev_ff <= 1'b1;
            press_flag_ff <= 1'b0;
            release_flag_ff <= 1'b0;
            bw_ff <= BW_RESET;
            irq_src_ff <= IRQ_SRC_IDLE;
            irq_pending_ff <= 1'b0;
            keepalive_ff <= KEEPALIVE_RESET;
        end
        else
        begin
            btn_s1_ff <= i_button_n;
            btn_s2_ff <= btn_s1_ff;
            btn_prev_ff <= btn_s2_ff;
            // Set wins over the clear made by reading the source byte
            press_flag_ff <= press_event || (press_flag_ff && !rd_irq_src);
            release_flag_ff <= release_event || (release_flag_ff && !rd_irq_src);
            if (i_sleep_entry)
                bw_ff <= {bw_ff[7:6], 6'h00};
            else if (wr_bw)
                bw_ff <= wbyte & 8'hC3;
            irq_src_ff <= nxt_irq_src;
            irq_pending_ff <= nxt_irq_src != IRQ_SRC_IDLE;
            if (wr_keep)
                keepalive_ff <= wbyte[CTRL_ENABLE_BIT];
        end
    end

    // Software power cycle timer; writing zero while waiting cancels it
    always_comb
    begin
        nxt_spc_state = spc_state_ff;
        unique case (spc_state_ff)
            SPC_IDLE:
                if (wr_spc && wbyte[SPC_BIT])
                    nxt_spc_state = SPC_WAIT;
            SPC_WAIT:
                if (spc_fire || (wr_spc && !wbyte[SPC_BIT]))
                    nxt_spc_state = SPC_IDLE;
        endcase
    end

    // Timer, action pulses and reset-cause flags
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            spc_state_ff <= SPC_IDLE;
            spc_cnt_ff <= '0;
            soft_reset_start_ff <= 1'b0;
            power_cycle_start_ff <= 1'b0;
            power_cycled_ff <= 1'b0;
            soft_reset_flag_ff <= 1'b0;
        end
        else
        begin
            spc_state_ff <= nxt_spc_state;
            spc_cnt_ff <= (spc_state_ff == SPC_WAIT) ? spc_cnt_ff + 1'b1 : '0;
            soft_reset_start_ff <= wd_soft;
            power_cycle_start_ff <= nxt_power_cycle;
            // Flags clear only the bits the host saw; a new event still wins
            power_cycled_ff <= nxt_power_cycle ||
                (power_cycled_ff && !(rd_cause && rd_byte_ff[RC_POWER_CYCLED_BIT]));
            soft_reset_flag_ff <= wd_soft ||
                (soft_reset_flag_ff && !(rd_cause && rd_byte_ff[RC_SOFT_RESET_BIT]));
        end
    end

    assign o_apb = apb_rsp_ff;
    assign o_keepalive_enable = keepalive_ff;
    assign o_irq_pending = irq_pending_ff;
    assign o_soft_reset_start = soft_reset_start_ff;
    assign o_power_cycle_start = power_cycle_start_ff;
    assign o_pin_cfg = pin_cfg_ff;

    a_press_flag_set: assert property (press_event |=> press_flag_ff && (irq_src_ff == BUTTON_BLOCK_ADDR))
        else $error("press event did not set flag and source");
    a_release_flag_set: assert property (release_event |=> release_flag_ff)
        else $error("release event did not set flag");
    a_flag_holds: assert property (press_flag_ff && !rd_irq_src |=> press_flag_ff)
        else $error("press flag dropped without source read");
    a_sleep_clears_wd: assert property (i_sleep_entry |=> (bw_ff[1:0] == 2'b00))
        else $error("sleep entry left watchdog armed");
    a_wd_soft_reset: assert property (i_watchdog_expired && bw_ff[1:0] == 2'b10 |=> o_soft_reset_start ##1
        soft_reset_flag_ff)
        else $error("watchdog soft reset not started");
    a_wd_power_cycle: assert property (i_watchdog_expired && bw_ff[BW_WD_CYCLE_BIT] |=> o_power_cycle_start)
        else $error("watchdog power cycle not started");
    a_spc_delay_count: assert property (spc_state_ff == SPC_WAIT && spc_cnt_ff < SPC_LAST
        && !wr_spc && !wd_cycle |=> spc_state_ff == SPC_WAIT && !o_power_cycle_start)
        else $error("power cycle fired before full delay");
    a_cycle_sets_flag: assert property (o_power_cycle_start |-> power_cycled_ff)
        else $error("power cycled flag not set");
    a_src_read_restore: assert property (rd_irq_src && irq_src_ff == rd_byte_ff && !press_event && !release_event
        && fault_event == 2'b00 |=> irq_src_ff == IRQ_SRC_IDLE)
        else $error("source byte not restored after read");
    a_pready_single: assert property (o_apb.pready |=> !o_apb.pready)
        else $error("pready held longer than one cycle");

    c_press_irq: cover property (press_event ##1 press_flag_ff);
    c_src_read: cover property (rd_irq_src && irq_src_ff != IRQ_SRC_IDLE);
    c_spc_fire: cover property (spc_fire ##1 o_power_cycle_start);
    c_wd_soft: cover property (wd_soft);
endmodule
`default_nettype wire

// >>> sim/psc_host_model.sv
/*
 Host side model: an APB master that runs one transfer for each request.
 Assumes the requester holds i_go until o_done pulses.
*/
`default_nettype none
module psc_host_model
    import psc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_write,
    input wire logic [APB_AW-1:0] i_addr,
    input wire logic [APB_DW-1:0] i_wdata,
    input wire psc_apb_rsp_t i_apb,
    output psc_apb_req_t o_apb,
    output logic o_done,
    output logic [APB_DW-1:0] o_rdata,
    output logic o_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_ff;
    // Request held until pready; released address and data lines carry inverted junk, not stale values
    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            phase_ff <= 2'd0;
            o_done <= 1'b0;
            o_apb <= '0;
        end
        else if (phase_ff == 2'd0)
        begin
            o_done <= 1'b0;
            if (i_go && !o_done)
            begin
                o_apb.psel <= 1'b1;
                o_apb.pwrite <= i_write;
                o_apb.paddr <= i_addr;
                o_apb.pwdata <= i_wdata;
                phase_ff <= 2'd1;
            end
        end
        else if (phase_ff == 2'd1)
        begin
            o_apb.penable <= 1'b1;
            phase_ff <= 2'd2;
        end
        else if (i_apb.pready === 1'b1)
        begin
            o_apb.psel <= 1'b0;
            o_apb.penable <= 1'b0;
            o_apb.paddr <= ~o_apb.paddr;
            o_apb.pwdata <= ~o_apb.pwdata;
            o_rdata <= i_apb.prdata;
            o_err <= i_apb.pslverr;
            o_done <= 1'b1;
            phase_ff <= 2'd0;
        end
    end
endmodule
`default_nettype wire

// >>> sim/pmu_system_control_register_bank_test.sv
/*
 Self-checking bench of the register bank against a register mirror.
 Assumes the host model as bus master and a shortened power cycle delay.
*/
`default_nettype none
module pmu_system_control_register_bank_test;
    import psc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SPD = 20;
    logic i_core_clk, i_rst, btn_n, wd, slp, go, wr, done, err, ka, irq, srs, pcs, ebit;
    logic [1:0] pg, flt, reg_en, reg_bl;
    logic [1:0][5:0] reg_lv;
    psc_pin_cfg_t [3:0] pin;
    psc_apb_req_t apb_req;
    psc_apb_rsp_t apb_rsp;
    logic [11:0] adr;
    logic [31:0] wdt, rdat, v;
    int miscompares, n_checks, seed, cyc, t0, mdl[int];
    logic [7:0] rw_idx [10] = '{8'h90, 8'h91, 8'hA0, 8'hA1, 8'hB1, 8'hC0, 8'hE3, 8'hE4, 8'hF4, 8'hF5};
    logic [7:0] rw_msk [10] = '{8'h3F, 8'h86, 8'h3F, 8'h86, 8'h80, 8'hC3, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    psc_host_model host_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_go(go), .i_write(wr), .i_addr(adr),
        .i_wdata(wdt), .i_apb(apb_rsp), .o_apb(apb_req), .o_done(done), .o_rdata(rdat), .o_err(err));
    psc_register_bank #(.SPC_DELAY_CYCLES(SPD)) dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_apb(apb_req), .o_apb(apb_rsp), .i_power_good(pg), .i_reg_fault(flt), .i_button_n(btn_n),
        .i_watchdog_expired(wd), .i_sleep_entry(slp), .o_reg_enable(reg_en), .o_reg_bleed(reg_bl),
        .o_reg_level(reg_lv), .o_keepalive_enable(ka), .o_irq_pending(irq), .o_soft_reset_start(srs),
        .o_power_cycle_start(pcs), .o_pin_cfg(pin));

    // Free clock and a cycle count for delay measurement
    initial
    begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) cyc <= cyc + 1;

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer; a lost handshake ends the run
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        @(posedge i_core_clk);
        go <= 1'b1;
        wr <= w;
        adr <= {2'b00, idx, 2'b00};
        wdt <= d;
        n = 0;
        while (done !== 1'b1 && n < 50)
        begin
            @(negedge i_core_clk);
            n++;
        end
        if (n == 50)
        begin
            miscompares++;
            conclude();
        end
        r = rdat;
        e = err;
        @(posedge i_core_clk);
        go <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        bus(1'b0, idx, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic wt(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        bus(1'b1, idx, d, r, e);
    endtask

    // One-cycle pulse on the watchdog input (0) or the sleep input (1)
    task automatic pulse(input logic which);
        @(posedge i_core_clk);
        if (which)
            slp <= 1'b1;
        else
            wd <= 1'b1;
        @(posedge i_core_clk);
        slp <= 1'b0;
        wd <= 1'b0;
        @(negedge i_core_clk);
    endtask

    initial
    begin
        seed = 84874;
        cyc = 0;
        {i_rst, btn_n, wd, slp, go, wr, pg, flt, adr, wdt} = {2'b11, 52'h0};
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        foreach (rw_idx[i]) mdl[rw_idx[i]] = 0;
        mdl[8'hB1] = 32'h80;
        foreach (rw_idx[i]) rd(rw_idx[i], mdl[rw_idx[i]]);
        rd(8'hC1, 32'hFF);
        rd(8'hC5, 32'h00);
        chk({ka, irq}, 2'b10);
        $display("test reset done");
        repeat (2) foreach (rw_idx[i])
        begin
            v = $random(seed);
            wt(rw_idx[i], v);
            mdl[rw_idx[i]] = v & rw_msk[i];
            rd(rw_idx[i], mdl[rw_idx[i]]);
        end
        chk({reg_en, reg_lv}, {mdl[8'hA1][7], mdl[8'h91][7], mdl[8'hA0][5:0], mdl[8'h90][5:0]});
        chk(reg_bl, {mdl[8'hA1][2] & ~mdl[8'hA1][7], mdl[8'h91][2] & ~mdl[8'h91][7]});
        chk(ka, mdl[8'hB1][7]);
        chk(pin, {mdl[8'hE3][7:0], mdl[8'hE4][7:0], mdl[8'hF5][7:0], mdl[8'hF4][7:0]});
        bus(1'b0, 8'hFF, 32'h0, v, ebit);
        chk(v, 32'h0);
        chk(ebit, 1'b1);
        pg <= 2'b11;
        repeat (4) @(posedge i_core_clk);
        rd(8'h91, mdl[8'h91] | 1);
        rd(8'hA1, mdl[8'hA1] | 1);
        $display("test fields done");
        wt(8'hC0, 32'hC0);
        btn_n <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        chk(irq, 1'b1);
        rd(8'hC2, 32'hA0);
        rd(8'hC1, 32'hC0);
        rd(8'hC1, 32'hFF);
        rd(8'hC2, 32'h20);
        chk(irq, 1'b0);
        btn_n <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        rd(8'hC2, 32'h40);
        rd(8'hC1, 32'hC0);
        wt(8'h91, 32'h02);
        wt(8'hA1, 32'h00);
        flt <= 2'b10;
        repeat (8) @(posedge i_core_clk);
        rd(8'hC1, 32'hFF);
        flt <= 2'b11;
        repeat (8) @(posedge i_core_clk);
        rd(8'hC1, 32'h90);
        $display("test interrupts done");
        wt(8'hC0, 32'h02);
        pulse(1'b0);
        chk({srs, pcs}, 2'b10);
        rd(8'hC5, 32'h01);
        rd(8'hC5, 32'h00);
        wt(8'hC0, 32'h03);
        pulse(1'b0);
        chk({srs, pcs}, 2'b01);
        rd(8'hC5, 32'h02);
        pulse(1'b1);
        rd(8'hC0, 32'h00);
        wt(8'hC3, 32'h01);
        t0 = cyc;
        rd(8'hC3, 32'h01);
        while (pcs !== 1'b1 && cyc - t0 < 100) @(negedge i_core_clk);
        chk(cyc - t0 >= SPD - 2 && cyc - t0 <= SPD + 2, 1'b1);
        rd(8'hC5, 32'h02);
        $display("test watchdog done");
        conclude();
    end
endmodule
`default_nettype wire
